// ---- src/hss_mode_pkg.sv ----
// constants shared by the high-side switch mode controller
package hss_mode_pkg;
   // clock
   localparam int CLK_PERIOD_PS = 4000;
   // shutdown to low-power qualification: low-power request held longer than this
   localparam int LP_HOLD_US = 500;
   localparam int LP_HOLD_CYCLES = (LP_HOLD_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
   // short-circuit response bound, longest time
   localparam int SC_RESPONSE_NS = 5000;
   localparam int SC_RESPONSE_CYCLES = (SC_RESPONSE_NS * 1000) / CLK_PERIOD_PS;
   // low-power short-circuit response bound, longest time
   localparam int LP_SC_RESPONSE_NS = 5000;
   localparam int LP_SC_RESPONSE_CYCLES = (LP_SC_RESPONSE_NS * 1000) / CLK_PERIOD_PS;
   // default auto-retry wait and overcurrent integration time in cycles
   localparam int RETRY_CYCLES_DEFAULT = 250000;
   localparam int OC_INTEGRATE_CYCLES_DEFAULT = 1024;
   // positions of the comparator and pin inputs in the synchronised vector
   localparam int IN_WIDTH = 13;
   localparam int IN_POR_OK = 0;
   localparam int IN_ENABLE = 1;
   localparam int IN_UVLO_OK = 2;
   localparam int IN_LP_REQ_N = 3;
   localparam int IN_SWITCH = 4;
   localparam int IN_BOOT_OK = 5;
   localparam int IN_MAIN_OC = 6;
   localparam int IN_MAIN_SC = 7;
   localparam int IN_BYPASS_SC = 8;
   localparam int IN_LOAD_WAKE = 9;
   localparam int IN_MAIN_FULL = 10;
   localparam int IN_BYPASS_GOOD = 11;
   localparam int IN_LATCH_OFF = 12;
   // values after reset
   localparam logic RST_GATE = 1'b0;
   localparam logic RST_WAKE = 1'b0;
   localparam logic RST_FAULT_N = 1'b1;
   localparam logic RST_ENABLE = 1'b0;
   // device modes
   typedef enum logic [6:0] {
      ST_OFF   = 7'b000_0001, // supply below power-on level
      ST_SHUT  = 7'b000_0010, // shutdown
      ST_QUAL  = 7'b000_0100, // qualifying low-power request from shutdown
      ST_LP    = 7'b000_1000, // low-power mode
      ST_WAKE  = 7'b001_0000, // load wakeup
      ST_ACT   = 7'b010_0000, // active mode
      ST_FAULT = 7'b100_0000  // tripped, retry wait or latched off
   } mode_e;
endpackage

// ---- src/pin_sync.sv ----
// three-stage synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk, // system clock
   input wire logic arst_n, // asynchronous reset, active low
   input wire logic [WIDTH-1:0] din, // asynchronous inputs
   output logic [WIDTH-1:0] dout // filtered synchronous copy
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;

   // refuse a width that the chain cannot serve
   if (WIDTH < 1) begin
      $error("pin_sync width must be at least one");
   end

   // stage chain; only s2 reads s1
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // a bit changes only once the second and third stage agree
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dout <= '0;
      end else begin
         dout <= (s2 & s3) | (dout & (s2 ^ s3));
      end
   end
endmodule

// ---- src/hold_timer.sv ----
// saturating run-time counter that flags when a hold time has elapsed
`timescale 1ns/1ps
module hold_timer #(
   parameter int LIMIT = 16
) (
   input wire logic clk, // system clock
   input wire logic arst_n, // asynchronous reset, active low
   input wire logic run, // count while high, clear while low
   output logic expired // high once run has lasted LIMIT cycles
);
   localparam int WIDTH = $clog2(LIMIT + 1);
   localparam logic [WIDTH-1:0] LIM = WIDTH'(LIMIT);
   localparam logic [WIDTH-1:0] LIM_M1 = WIDTH'(LIMIT - 1);
   logic [WIDTH-1:0] count;

   // refuse a limit that the compare cannot serve
   if (LIMIT < 2) begin
      $error("hold_timer limit must be at least two");
   end

   // count up while running, restart from zero whenever run drops
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= '0;
         expired <= 1'b0;
      end else if (!run) begin
         count <= '0;
         expired <= 1'b0;
      end else begin
         if (count != LIM) begin
            count <= count + WIDTH'(1);
         end
         expired <= (count >= LIM_M1);
      end
   end
endmodule

// ---- src/hss_mode_ctrl.sv ----
// mode state machine and gate control of the high-side switch controller
`timescale 1ns/1ps
//
// Function
// - undervoltage input low forces both gates low
// - supply below power-on level: all off
// - enable low with supply up: shutdown
// - enable with request released goes straight active
// - request asserted in active enters low-power
// - low-power: bypass on, main off, wake high
// - low-power exits on release or load wakeup
// - wakeup: main first, then bypass off, wake low
// - load-wakeup state holds until request released
// - low-power undervoltage turns bypass gate off
// - low-power bootstrap undervoltage: bypass off, fault
// - bypass short before gate good forces wakeup
// - short in wakeup: both gates off, fault
// - active: main follows switch, bypass off, wake low
// - active undervoltage turns main gate off
// - active bootstrap undervoltage: main off, fault
// - integrated overcurrent trips main gate, fault
// - active short circuit trips main gate, fault
// - latch cleared by edge, request, enable, power
// - bootstrap recovery releases fault and gate drive
module hss_mode_ctrl #(
   parameter int LP_HOLD_CYCLES = hss_mode_pkg::LP_HOLD_CYCLES,
   parameter int RETRY_CYCLES = hss_mode_pkg::RETRY_CYCLES_DEFAULT,
   parameter int OC_INTEGRATE_CYCLES = hss_mode_pkg::OC_INTEGRATE_CYCLES_DEFAULT
) (
   input wire logic clk, // 250 MHz system clock
   input wire logic arst_n, // asynchronous reset, active low
   input wire logic supply_por_ok, // supply above power-on level
   input wire logic enable_undervoltage_input, // enable pin above shutdown threshold
   input wire logic enable_uvlo_ok, // enable pin above undervoltage falling level
   input wire logic low_power_request_n, // low-power request, active low
   input wire logic main_switch_input, // main switch command
   input wire logic bootstrap_ok, // bootstrap to source above undervoltage level
   input wire logic main_overcurrent, // main sense above overcurrent start threshold
   input wire logic main_short_circuit, // main sense above short-circuit threshold
   input wire logic bypass_short_circuit, // bypass sense above short-circuit threshold
   input wire logic load_wakeup_detect, // load current above load wakeup threshold
   input wire logic main_gate_full, // main gate fully enhanced
   input wire logic bypass_gate_good, // bypass gate reached gate-good level
   input wire logic latch_off_mode, // high: latch off, low: auto-retry
   output logic main_gate_drive, // main path gate on
   output logic bypass_gate_drive, // bypass path gate on
   output logic wake_out, // wake indication
   output logic fault_out_n, // fault indication, active low
   output logic charge_pump_en, // charge pump enabled
   output logic protect_en // protections enabled
);
   logic [hss_mode_pkg::IN_WIDTH-1:0] raw_in;
   logic [hss_mode_pkg::IN_WIDTH-1:0] sync_in;
   logic por_ok;
   logic en_ok;
   logic uvlo_ok;
   logic lp_req_n;
   logic sw_in;
   logic boot_ok;
   logic oc_over;
   logic sc_main;
   logic sc_bypass;
   logic load_wake;
   logic main_full;
   logic bypass_good;
   logic latch_cfg;
   logic sw_prev;
   logic sw_fall;
   logic qual_done;
   logic retry_done;
   logic oc_trip;
   logic handover;
   logic [$clog2(OC_INTEGRATE_CYCLES + 1)-1:0] oc_count;
   hss_mode_pkg::mode_e state;
   hss_mode_pkg::mode_e next_state;
   logic next_main;
   logic next_bypass;
   logic next_wake;
   logic next_fault_n;
   logic next_cp;
   logic next_prot;

   localparam int OCW = $clog2(OC_INTEGRATE_CYCLES + 1);
   localparam logic [OCW-1:0] OC_LIM_M1 = OCW'(OC_INTEGRATE_CYCLES - 1);

   // refuse counts that the timers cannot serve
   if (LP_HOLD_CYCLES < 2 || RETRY_CYCLES < 2 || OC_INTEGRATE_CYCLES < 2) begin
      $error("hss_mode_ctrl counts must be at least two");
   end

   // true in modes where the charge pump and protections run
   function automatic logic powered_mode(input hss_mode_pkg::mode_e s);
      powered_mode = (s == hss_mode_pkg::ST_LP) || (s == hss_mode_pkg::ST_WAKE) ||
                     (s == hss_mode_pkg::ST_ACT) || (s == hss_mode_pkg::ST_FAULT);
   endfunction

   // gather comparator and pin inputs for the synchroniser
   assign raw_in = {latch_off_mode, bypass_gate_good, main_gate_full, load_wakeup_detect,
                    bypass_short_circuit, main_short_circuit, main_overcurrent, bootstrap_ok,
                    main_switch_input, low_power_request_n, enable_uvlo_ok,
                    enable_undervoltage_input, supply_por_ok};

   // every comparator result enters through the synchroniser
   pin_sync #(
      .WIDTH(hss_mode_pkg::IN_WIDTH)
   ) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .din(raw_in),
      .dout(sync_in)
   );

   // named views of the synchronised inputs
   assign por_ok = sync_in[hss_mode_pkg::IN_POR_OK];
   assign en_ok = sync_in[hss_mode_pkg::IN_ENABLE];
   assign uvlo_ok = sync_in[hss_mode_pkg::IN_UVLO_OK];
   assign lp_req_n = sync_in[hss_mode_pkg::IN_LP_REQ_N];
   assign sw_in = sync_in[hss_mode_pkg::IN_SWITCH];
   assign boot_ok = sync_in[hss_mode_pkg::IN_BOOT_OK];
   assign oc_over = sync_in[hss_mode_pkg::IN_MAIN_OC];
   assign sc_main = sync_in[hss_mode_pkg::IN_MAIN_SC];
   assign sc_bypass = sync_in[hss_mode_pkg::IN_BYPASS_SC];
   assign load_wake = sync_in[hss_mode_pkg::IN_LOAD_WAKE];
   assign main_full = sync_in[hss_mode_pkg::IN_MAIN_FULL];
   assign bypass_good = sync_in[hss_mode_pkg::IN_BYPASS_GOOD];
   assign latch_cfg = sync_in[hss_mode_pkg::IN_LATCH_OFF];
   assign sw_fall = sw_prev && !sw_in;
   assign oc_trip = (oc_count == OC_LIM_M1) && oc_over && main_gate_drive;

   // switch input history for falling-edge latch clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sw_prev <= 1'b0;
      end else begin
         sw_prev <= sw_in;
      end
   end

   // low-power request must be held while enable qualifies
   hold_timer #(
      .LIMIT(LP_HOLD_CYCLES)
   ) u_qual_timer (
      .clk(clk),
      .arst_n(arst_n),
      .run(state == hss_mode_pkg::ST_QUAL),
      .expired(qual_done)
   );

   // auto-retry wait; cleared whenever the fault state is left
   hold_timer #(
      .LIMIT(RETRY_CYCLES)
   ) u_retry_timer (
      .clk(clk),
      .arst_n(arst_n),
      .run((state == hss_mode_pkg::ST_FAULT) && !latch_cfg),
      .expired(retry_done)
   );

   // energy integrator: counts in active mode while main conducts above the start threshold
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         oc_count <= '0;
      end else if (state == hss_mode_pkg::ST_ACT && oc_over && main_gate_drive && !oc_trip) begin
         oc_count <= oc_count + OCW'(1);
      end else begin
         oc_count <= '0;
      end
   end

   // load wakeup handover: main fully on releases bypass and wake
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         handover <= 1'b0;
      end else if (state != hss_mode_pkg::ST_WAKE) begin
         handover <= 1'b0;
      end else if (main_full && main_gate_drive) begin
         handover <= 1'b1;
      end
   end

   // mode transitions; supply and enable loss override every exit, short circuit is tested first in wakeup and active
   always_comb begin
      next_state = state;
      unique case (state)
         hss_mode_pkg::ST_OFF: begin
            next_state = hss_mode_pkg::ST_SHUT;
         end
         hss_mode_pkg::ST_SHUT: begin
            if (en_ok) begin
               next_state = lp_req_n ? hss_mode_pkg::ST_ACT : hss_mode_pkg::ST_QUAL;
            end
         end
         hss_mode_pkg::ST_QUAL: begin
            if (lp_req_n) begin
               next_state = hss_mode_pkg::ST_ACT;
            end else if (qual_done) begin
               next_state = hss_mode_pkg::ST_LP;
            end
         end
         hss_mode_pkg::ST_LP: begin
            if (lp_req_n) begin
               next_state = hss_mode_pkg::ST_ACT;
            end else if ((sc_bypass && !bypass_good) || load_wake) begin
               next_state = hss_mode_pkg::ST_WAKE;
            end
         end
         hss_mode_pkg::ST_WAKE: begin
            if (sc_main) begin
               next_state = hss_mode_pkg::ST_FAULT;
            end else if (lp_req_n) begin
               next_state = hss_mode_pkg::ST_ACT;
            end
         end
         hss_mode_pkg::ST_ACT: begin
            if (sc_main || oc_trip) begin
               next_state = hss_mode_pkg::ST_FAULT;
            end else if (!lp_req_n) begin
               next_state = hss_mode_pkg::ST_LP;
            end
         end
         hss_mode_pkg::ST_FAULT: begin
            if (!lp_req_n) begin
               next_state = hss_mode_pkg::ST_LP;
            end else if (latch_cfg ? sw_fall : retry_done) begin
               next_state = hss_mode_pkg::ST_ACT;
            end
         end
      endcase
      if (!por_ok) begin
         next_state = hss_mode_pkg::ST_OFF;
      end else if (!en_ok) begin
         next_state = hss_mode_pkg::ST_SHUT;
      end
   end

   // output levels for the mode being entered
   always_comb begin
      next_cp = powered_mode(next_state);
      next_prot = powered_mode(next_state);
      next_main = 1'b0;
      next_bypass = 1'b0;
      next_wake = 1'b0;
      unique case (next_state)
         hss_mode_pkg::ST_LP: begin
            next_bypass = uvlo_ok && boot_ok;
            next_wake = 1'b1;
         end
         hss_mode_pkg::ST_WAKE: begin
            next_main = uvlo_ok && boot_ok;
            next_bypass = uvlo_ok && boot_ok && !handover;
            next_wake = !handover;
         end
         hss_mode_pkg::ST_ACT: begin
            next_main = sw_in && uvlo_ok && boot_ok;
         end
         default: begin
            next_main = 1'b0;
         end
      endcase
      if (!uvlo_ok) begin
         next_main = 1'b0;
         next_bypass = 1'b0;
      end
      next_fault_n = !((next_state == hss_mode_pkg::ST_FAULT) ||
                       (powered_mode(next_state) && !boot_ok));
   end

   // mode register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= hss_mode_pkg::ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   // registered outputs
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         main_gate_drive <= hss_mode_pkg::RST_GATE;
         bypass_gate_drive <= hss_mode_pkg::RST_GATE;
         wake_out <= hss_mode_pkg::RST_WAKE;
         fault_out_n <= hss_mode_pkg::RST_FAULT_N;
         charge_pump_en <= hss_mode_pkg::RST_ENABLE;
         protect_en <= hss_mode_pkg::RST_ENABLE;
      end else begin
         main_gate_drive <= next_main;
         bypass_gate_drive <= next_bypass;
         wake_out <= next_wake;
         fault_out_n <= next_fault_n;
         charge_pump_en <= next_cp;
         protect_en <= next_prot;
      end
   end

   // checks on the mode machine and gate outputs
   chk_uvlo_gates_low: assert property (@(posedge clk) disable iff (!arst_n)
      !uvlo_ok |=> !main_gate_drive && !bypass_gate_drive)
      else $error("gates on after undervoltage");
   chk_por_all_off: assert property (@(posedge clk) disable iff (!arst_n)
      !por_ok |=> state == hss_mode_pkg::ST_OFF && !main_gate_drive && !bypass_gate_drive && !charge_pump_en)
      else $error("not off below power-on level");
   chk_enable_shutdown: assert property (@(posedge clk) disable iff (!arst_n)
      por_ok && !en_ok |=> state == hss_mode_pkg::ST_SHUT && !protect_en && !main_gate_drive)
      else $error("shutdown not entered");
   chk_active_to_lp: assert property (@(posedge clk) disable iff (!arst_n)
      state == hss_mode_pkg::ST_ACT && por_ok && en_ok && !lp_req_n && !sc_main && !oc_trip
      |=> state == hss_mode_pkg::ST_LP)
      else $error("active did not enter low-power");
   chk_lp_outputs: assert property (@(posedge clk) disable iff (!arst_n)
      state == hss_mode_pkg::ST_LP && $past(state) == hss_mode_pkg::ST_LP
      |-> wake_out && !main_gate_drive && charge_pump_en)
      else $error("low-power outputs wrong");
   chk_wake_handover: assert property (@(posedge clk) disable iff (!arst_n)
      $fell(bypass_gate_drive) && state == hss_mode_pkg::ST_WAKE && $past(uvlo_ok && boot_ok)
      |-> handover && main_gate_drive)
      else $error("bypass dropped before main fully on");
   chk_bypass_short: assert property (@(posedge clk) disable iff (!arst_n)
      state == hss_mode_pkg::ST_LP && por_ok && en_ok && !lp_req_n && sc_bypass && !bypass_good
      && uvlo_ok && boot_ok |=> state == hss_mode_pkg::ST_WAKE && main_gate_drive)
      else $error("bypass short did not wake main");
   chk_wake_short: assert property (@(posedge clk) disable iff (!arst_n)
      state == hss_mode_pkg::ST_WAKE && por_ok && en_ok && sc_main
      |=> !main_gate_drive && !bypass_gate_drive && !fault_out_n)
      else $error("short in wakeup not tripped");
   chk_boot_fault: assert property (@(posedge clk) disable iff (!arst_n)
      (state == hss_mode_pkg::ST_ACT || state == hss_mode_pkg::ST_LP) && por_ok && en_ok && !boot_ok
      |=> !fault_out_n && !main_gate_drive && !bypass_gate_drive)
      else $error("bootstrap undervoltage not handled");
   chk_active_short: assert property (@(posedge clk) disable iff (!arst_n)
      state == hss_mode_pkg::ST_ACT && por_ok && en_ok && sc_main
      |=> state == hss_mode_pkg::ST_FAULT && !main_gate_drive && !fault_out_n)
      else $error("active short not tripped");
endmodule

// ---- bench/fet_model.sv ----
// behavioural model of the external main and bypass transistors
`timescale 1ns/1ps
module fet_model #(
   parameter int MAIN_DLY = 3, // prompt main gate enhancement
   parameter int BYP_DLY = 40 // slow bypass gate charge
) (
   input wire logic clk, // system clock
   input wire logic arst_n, // asynchronous reset, active low
   input wire logic main_gate_drive, // main gate command
   input wire logic bypass_gate_drive, // bypass gate command
   output logic main_gate_full, // main gate fully enhanced
   output logic bypass_gate_good // bypass gate at gate-good level
);
   int main_cnt;
   int byp_cnt;
   // gate charge counters restart whenever the drive drops, so a gate off never reads as good
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         main_cnt <= 0;
         byp_cnt <= 0;
      end else begin
         main_cnt <= main_gate_drive ? (main_cnt < MAIN_DLY ? main_cnt + 1 : main_cnt) : 0;
         byp_cnt <= bypass_gate_drive ? (byp_cnt < BYP_DLY ? byp_cnt + 1 : byp_cnt) : 0;
      end
   end
   assign main_gate_full = main_gate_drive && (main_cnt >= MAIN_DLY);
   assign bypass_gate_good = bypass_gate_drive && (byp_cnt >= BYP_DLY);
endmodule

// ---- bench/test_hss_mode_ctrl.sv ----
// self-checking testbench of the high-side switch mode controller
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
`define WAITFOR(c, n) for (int k_ = 0; k_ < (n) && !(c); k_++) @(negedge clk);
module test_hss_mode_ctrl;
   logic clk = 1'b0, arst_n = 1'b0;
   logic supply_por_ok = 1'b0, enable_undervoltage_input = 1'b0, enable_uvlo_ok = 1'b1;
   logic low_power_request_n = 1'b1, main_switch_input = 1'b0, bootstrap_ok = 1'b1;
   logic main_overcurrent = 1'b0, main_short_circuit = 1'b0, bypass_short_circuit = 1'b0;
   logic load_wakeup_detect = 1'b0, latch_off_mode = 1'b0;
   logic main_gate_full, bypass_gate_good;
   logic main_gate_drive, bypass_gate_drive, wake_out, fault_out_n, charge_pump_en, protect_en;
   int error_cnt = 0;
   int num_checks = 0;

   hss_mode_ctrl #(.LP_HOLD_CYCLES(20), .RETRY_CYCLES(30), .OC_INTEGRATE_CYCLES(8)) hss_mode_ctrl_i (
      .clk(clk), .arst_n(arst_n), .supply_por_ok(supply_por_ok),
      .enable_undervoltage_input(enable_undervoltage_input), .enable_uvlo_ok(enable_uvlo_ok),
      .low_power_request_n(low_power_request_n), .main_switch_input(main_switch_input),
      .bootstrap_ok(bootstrap_ok), .main_overcurrent(main_overcurrent),
      .main_short_circuit(main_short_circuit), .bypass_short_circuit(bypass_short_circuit),
      .load_wakeup_detect(load_wakeup_detect), .main_gate_full(main_gate_full),
      .bypass_gate_good(bypass_gate_good), .latch_off_mode(latch_off_mode),
      .main_gate_drive(main_gate_drive), .bypass_gate_drive(bypass_gate_drive), .wake_out(wake_out),
      .fault_out_n(fault_out_n), .charge_pump_en(charge_pump_en), .protect_en(protect_en));

   fet_model #(.MAIN_DLY(3), .BYP_DLY(40)) fet_model_i (
      .clk(clk), .arst_n(arst_n), .main_gate_drive(main_gate_drive), .bypass_gate_drive(bypass_gate_drive),
      .main_gate_full(main_gate_full), .bypass_gate_good(bypass_gate_good));

   // 250 MHz clock
   initial begin
      forever #2 clk = ~clk;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // supply low after reset: everything off
   task automatic t_power_down();
      repeat (10) @(negedge clk);
      `CHK({main_gate_drive, bypass_gate_drive, wake_out, charge_pump_en, protect_en}, 5'h0)
      `CHK(fault_out_n, 1'b1)
   endtask

   // supply up, enable low: shutdown with gates low
   task automatic t_shutdown();
      supply_por_ok = 1'b1;
      enable_undervoltage_input = 1'b0;
      repeat (12) @(negedge clk);
      `CHK({main_gate_drive, bypass_gate_drive, charge_pump_en, protect_en}, 4'h0)
   endtask

   // enable with request held low: qualify, then low-power
   task automatic t_qualify_lp();
      enable_undervoltage_input = 1'b1;
      low_power_request_n = 1'b0;
      main_switch_input = 1'b1;
      repeat (15) @(negedge clk);
      `CHK({bypass_gate_drive, charge_pump_en}, 2'b00)
      `WAITFOR(bypass_gate_drive === 1'b1, 30)
      `CHK({main_gate_drive, bypass_gate_drive, wake_out, charge_pump_en}, 4'b0111)
      repeat (45) @(negedge clk);
   endtask

   // undervoltage and bootstrap loss while in low-power
   task automatic t_lp_protect();
      enable_uvlo_ok = 1'b0;
      `WAITFOR(bypass_gate_drive === 1'b0, 20)
      `CHK({main_gate_drive, bypass_gate_drive}, 2'b00)
      enable_uvlo_ok = 1'b1;
      `WAITFOR(bypass_gate_drive === 1'b1, 20)
      bootstrap_ok = 1'b0;
      `WAITFOR(fault_out_n === 1'b0, 20)
      `CHK(bypass_gate_drive, 1'b0)
      bootstrap_ok = 1'b1;
      `WAITFOR(fault_out_n === 1'b1, 20)
      `WAITFOR(bypass_gate_drive === 1'b1, 5)
      `CHK({bypass_gate_drive, fault_out_n}, 2'b11)
   endtask

   // request released: active, main follows the switch input
   task automatic t_lp_to_active();
      low_power_request_n = 1'b1;
      `WAITFOR(main_gate_drive === 1'b1, 20)
      `CHK({main_gate_drive, bypass_gate_drive, wake_out, protect_en}, 4'b1001)
      main_switch_input = 1'b0;
      `WAITFOR(main_gate_drive === 1'b0, 20)
      `CHK(main_gate_drive, 1'b0)
      main_switch_input = 1'b1;
      `WAITFOR(main_gate_drive === 1'b1, 20)
      `CHK(main_gate_drive, 1'b1)
   endtask

   // short, overcurrent, bootstrap and undervoltage while active
   task automatic t_active_faults();
      main_short_circuit = 1'b1;
      `WAITFOR(fault_out_n === 1'b0, 20)
      `CHK({main_gate_drive, fault_out_n, charge_pump_en}, 3'b001)
      main_short_circuit = 1'b0;
      `WAITFOR(fault_out_n === 1'b1, 60)
      `WAITFOR(main_gate_drive === 1'b1, 5)
      `CHK({main_gate_drive, fault_out_n}, 2'b11)
      main_overcurrent = 1'b1;
      repeat (4) @(negedge clk);
      main_overcurrent = 1'b0;
      repeat (12) @(negedge clk);
      `CHK({main_gate_drive, fault_out_n}, 2'b11)
      latch_off_mode = 1'b1;
      repeat (6) @(negedge clk);
      main_overcurrent = 1'b1;
      `WAITFOR(fault_out_n === 1'b0, 30)
      `CHK({main_gate_drive, fault_out_n}, 2'b00)
      main_overcurrent = 1'b0;
      repeat (60) @(negedge clk);
      `CHK({main_gate_drive, fault_out_n}, 2'b00)
      main_switch_input = 1'b0;
      `WAITFOR(fault_out_n === 1'b1, 20)
      main_switch_input = 1'b1;
      `WAITFOR(main_gate_drive === 1'b1, 20)
      `CHK({main_gate_drive, fault_out_n}, 2'b11)
      latch_off_mode = 1'b0;
      bootstrap_ok = 1'b0;
      `WAITFOR(fault_out_n === 1'b0, 20)
      `CHK(main_gate_drive, 1'b0)
      bootstrap_ok = 1'b1;
      `WAITFOR(main_gate_drive === 1'b1, 20)
      `CHK(fault_out_n, 1'b1)
      enable_uvlo_ok = 1'b0;
      `WAITFOR(main_gate_drive === 1'b0, 20)
      `CHK({main_gate_drive, bypass_gate_drive, fault_out_n}, 3'b001)
      enable_uvlo_ok = 1'b1;
      `WAITFOR(main_gate_drive === 1'b1, 20)
   endtask

   // load wakeup: main first, bypass handed over, hold until request released
   task automatic t_load_wakeup();
      low_power_request_n = 1'b0; // switch input kept high through entry
      `WAITFOR(bypass_gate_drive === 1'b1, 20)
      `CHK({main_gate_drive, wake_out}, 2'b01)
      repeat (50) @(negedge clk);
      load_wakeup_detect = 1'b1;
      `WAITFOR(main_gate_drive === 1'b1, 20)
      `CHK({main_gate_drive, bypass_gate_drive, wake_out}, 3'b111)
      `WAITFOR(bypass_gate_drive === 1'b0, 20)
      `CHK({main_gate_drive, bypass_gate_drive, wake_out}, 3'b100)
      load_wakeup_detect = 1'b0;
      repeat (30) @(negedge clk);
      `CHK({main_gate_drive, bypass_gate_drive, wake_out}, 3'b100)
      low_power_request_n = 1'b1;
      main_switch_input = 1'b0;
      `WAITFOR(main_gate_drive === 1'b0, 20)
      `CHK(main_gate_drive, 1'b0)
      main_switch_input = 1'b1;
      `WAITFOR(main_gate_drive === 1'b1, 20)
   endtask

   // bypass short before gate good, then a main short in wakeup
   task automatic t_bypass_short();
      low_power_request_n = 1'b0;
      `WAITFOR(bypass_gate_drive === 1'b1, 20)
      bypass_short_circuit = 1'b1;
      `WAITFOR(main_gate_drive === 1'b1, 10)
      `CHK({main_gate_drive, bypass_gate_good}, 2'b10)
      bypass_short_circuit = 1'b0;
      main_short_circuit = 1'b1;
      `WAITFOR(fault_out_n === 1'b0, 10)
      `CHK({main_gate_drive, bypass_gate_drive, fault_out_n}, 3'b000)
      main_short_circuit = 1'b0;
      low_power_request_n = 1'b1;
      `WAITFOR(main_gate_drive === 1'b1, 80)
      `CHK({main_gate_drive, fault_out_n}, 2'b11)
   endtask

   // supply drop from active, then shutdown again
   task automatic t_supply_drop();
      supply_por_ok = 1'b0;
      `WAITFOR(charge_pump_en === 1'b0, 20)
      `CHK({main_gate_drive, bypass_gate_drive, charge_pump_en, protect_en}, 4'h0)
      t_shutdown();
   endtask

   // enable with request released goes straight active; early release ends qualification
   task automatic t_direct_active();
      enable_undervoltage_input = 1'b1;
      `WAITFOR(main_gate_drive === 1'b1, 10)
      `CHK({main_gate_drive, bypass_gate_drive, wake_out, protect_en}, 4'h9)
      enable_undervoltage_input = 1'b0;
      `WAITFOR(protect_en === 1'b0, 10)
      `CHK({main_gate_drive, protect_en}, 2'b00)
      enable_undervoltage_input = 1'b1;
      low_power_request_n = 1'b0;
      repeat (10) @(negedge clk);
      `CHK({main_gate_drive, charge_pump_en}, 2'b00)
      low_power_request_n = 1'b1;
      `WAITFOR(main_gate_drive === 1'b1, 10)
      `CHK({main_gate_drive, bypass_gate_drive, wake_out, protect_en}, 4'h9)
   endtask

   // main sequence
   initial begin
      repeat (10) @(negedge clk);
      arst_n = 1'b1;
      t_power_down();
      t_shutdown();
      t_qualify_lp();
      t_lp_protect();
      t_lp_to_active();
      t_active_faults();
      t_load_wakeup();
      t_bypass_short();
      t_supply_drop();
      t_direct_active();
      finish_test();
   end

   // watchdog: the sequence takes under 2000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      finish_test();
   end
endmodule
